// >>> rtl/mbt_block_transfer.sv
// Marker block transfer engine with its byte FIFO
//
// Notes on behaviour
// - A double-word marker index x gives the byte offset (x-1)*4.
// - A word marker index x gives the byte offset (x-1)*2.
// - Parameter errors show on the error outputs all the time while running.
// - Every transfer moves single marker bytes whatever the address operand width.
// - The enable input activates the block when high if enable-release is set.
// - With enable-release cleared the block is always enabled and ignores enable.
// - Only a rising trigger edge starts a transfer; a steady high does not.
// - Byte-kind address inputs are byte offsets from the first marker byte, zero being that byte.
// - Fill mode reads one source byte and writes it to every destination byte.
// - Copy mode copies the whole block of count bytes from source to destination.
// - A word or double-word fill source uses its least significant byte.
// - Count overrun of either range raises the overrun error and blocks the transfer.
// - Range checks are evaluated every cycle, trigger or not.
// - Overlap is legal in copy mode and the legacy error output stays low.
// - A range outside memory or a zero count raises the range error and blocks.
`timescale 1ns/1ps
`include "mbt_defs.svh"

module mbt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `MBT_FIFO_DEPTH
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      fill;
   wire              push = i_in_valid && o_in_ready;
   wire              pop  = o_out_valid && i_out_ready;

   assign o_in_ready  = (fill != (PW+1)'(DEPTH));
   assign o_out_valid = (fill != '0);
   assign o_out_data  = mem[rd_ptr];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill   <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

module mbt_block_transfer #(
   parameter int AW        = 16,
   parameter int CW        = 16,
   parameter int MEM_BYTES = 512,
   parameter int MAW       = $clog2(MEM_BYTES)
) (
   input  wire logic           i_core_clk,
   input  wire logic           i_resetn,
   input  wire logic           i_enable,
   input  wire logic           i_enable_release,
   input  wire logic           i_trigger,
   input  wire logic           i_fill_mode,
   input  wire logic [AW-1:0]  i_source_offset,
   input  wire logic [1:0]     i_source_kind,
   input  wire logic [AW-1:0]  i_dest_offset,
   input  wire logic [1:0]     i_dest_kind,
   input  wire logic [CW-1:0]  i_count,
   output logic                o_mem_rd_en,
   output logic      [MAW-1:0] o_mem_rd_addr,
   input  wire logic           i_mem_rd_valid,
   input  wire logic [7:0]     i_mem_rd_data,
   output logic                o_mem_wr_en,
   output logic      [MAW-1:0] o_mem_wr_addr,
   output logic      [7:0]     o_mem_wr_data,
   input  wire logic           i_mem_wr_ready,
   output logic                o_busy,
   output logic                o_done,
   output logic                o_count_overrun_err,
   output logic                o_legacy_error_out,
   output logic                o_address_range_err
);
   localparam int LW = `MBT_LEN_W;

   logic                      rst_meta_n;
   logic                      rst_n;
   logic                      trig_q;
   mbt_pkg::mbt_rd_state_type rd_state;
   mbt_pkg::mbt_rd_state_type next_rd_state;
   logic                      fill_q;
   logic                      down_q;
   logic [7:0]                byte_q;
   logic [LW-1:0]             rd_left;
   logic [LW-1:0]             wr_left;
   logic [MAW-1:0]            wr_next;
   mbt_pkg::mbt_span_type     span;

   // Reset release through two flops
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   // raw byte offsets from the first marker byte
   wire [31:0] src_m1   = 32'(i_source_offset) - `MBT_INDEX_BASE;
   wire [31:0] dst_m1   = 32'(i_dest_offset) - `MBT_INDEX_BASE;
   assign span.src_off  = (i_source_kind == `MBT_KIND_WORD)  ? (src_m1 << `MBT_WORD_SHIFT)
                        : (i_source_kind == `MBT_KIND_DWORD) ? (src_m1 << `MBT_DWORD_SHIFT)
                        : 32'(i_source_offset);
   assign span.dst_off  = (i_dest_kind == `MBT_KIND_WORD)  ? (dst_m1 << `MBT_WORD_SHIFT)
                        : (i_dest_kind == `MBT_KIND_DWORD) ? (dst_m1 << `MBT_DWORD_SHIFT)
                        : 32'(i_dest_offset);

   // Index zero of a word or double word has no byte offset
   wire        src_bad  = (i_source_kind != `MBT_KIND_BYTE) && (i_source_offset == '0);
   wire        dst_bad  = (i_dest_kind != `MBT_KIND_BYTE) && (i_dest_offset == '0);
   wire [31:0] mem_size = 32'(MEM_BYTES);
   wire [31:0] count32  = 32'(i_count);
   // a fill source is the one byte at the operand's low address
   wire [31:0] src_len  = i_fill_mode ? `MBT_FILL_SRC_LEN : count32;

   // range outside memory or zero count
   wire range_err = src_bad || dst_bad || (i_count == '0)
                 || (span.src_off >= mem_size) || (span.dst_off >= mem_size);
   wire over_err  = !range_err
                 && ((count32 > 32'(`MBT_MAX_COUNT))
                 || (span.src_off + src_len > mem_size)
                 || (span.dst_off + count32 > mem_size));

   // release option cleared means always enabled
   // otherwise the enable input gates the block
   wire active    = !i_enable_release || i_enable;
   wire trig_rise = i_trigger && !trig_q;
   wire start     = active && trig_rise && !range_err && !over_err
                 && (rd_state == mbt_pkg::MBT_RD_IDLE) && !o_busy;

   // higher destination in copy mode walks downwards
   wire           go_down  = !i_fill_mode && (span.dst_off > span.src_off);
   wire [LW-1:0]  len      = LW'(i_count);
   wire [MAW-1:0] last_ofs = MAW'(i_count - CW'(1));
   wire [MAW-1:0] src_base = MAW'(span.src_off);
   wire [MAW-1:0] dst_base = MAW'(span.dst_off);
   wire [MAW-1:0] src_init = go_down ? src_base + last_ofs : src_base;
   wire [MAW-1:0] dst_init = go_down ? dst_base + last_ofs : dst_base;
   wire [MAW-1:0] rd_step  = down_q ? o_mem_rd_addr - 1'b1 : o_mem_rd_addr + 1'b1;
   wire [MAW-1:0] wr_step  = down_q ? wr_next - 1'b1 : wr_next + 1'b1;

   logic       f_in_ready;
   logic       f_out_valid;
   logic [7:0] f_out_data;
   wire        f_push   = (rd_state == mbt_pkg::MBT_RD_PUSH);
   wire        f_pull   = !o_mem_wr_en || i_mem_wr_ready;
   wire        pushed   = f_push && f_in_ready;
   wire        popped   = f_out_valid && f_pull;
   wire        wr_taken = o_mem_wr_en && i_mem_wr_ready;

   mbt_fifo #(
      .WIDTH (8),
      .DEPTH (`MBT_FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_core_clk),
      .i_rst_n     (rst_n),
      .i_in_valid  (f_push),
      .o_in_ready  (f_in_ready),
      .i_in_data   (byte_q),
      .o_out_valid (f_out_valid),
      .i_out_ready (f_pull),
      .o_out_data  (f_out_data)
   );

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_count_overrun_err <= 1'b0;
         o_address_range_err <= 1'b0;
         o_legacy_error_out  <= 1'b0;
         trig_q              <= 1'b0;
      end else begin
         o_count_overrun_err <= over_err;
         o_address_range_err <= range_err;
         o_legacy_error_out  <= 1'b0;
         trig_q              <= i_trigger;
      end
   end

   // Reader: fetches source bytes into the FIFO
   wire rd_last = (rd_left == LW'(1));
   wire rd_got  = (rd_state == mbt_pkg::MBT_RD_WAIT) && i_mem_rd_valid;

   always_comb begin
      next_rd_state = rd_state;
      case (rd_state)
         mbt_pkg::MBT_RD_IDLE: begin
            if (start) begin
               next_rd_state = mbt_pkg::MBT_RD_REQ;
            end
         end
         mbt_pkg::MBT_RD_REQ: begin
            next_rd_state = mbt_pkg::MBT_RD_WAIT;
         end
         mbt_pkg::MBT_RD_WAIT: begin
            if (i_mem_rd_valid) begin
               next_rd_state = mbt_pkg::MBT_RD_PUSH;
            end
         end
         mbt_pkg::MBT_RD_PUSH: begin
            if (pushed && rd_last) begin
               next_rd_state = mbt_pkg::MBT_RD_IDLE;
            end else if (pushed && !fill_q) begin
               next_rd_state = mbt_pkg::MBT_RD_REQ;
            end
         end
         default: begin
            next_rd_state = mbt_pkg::MBT_RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_state    <= mbt_pkg::MBT_RD_IDLE;
         o_mem_rd_en <= 1'h0;
      end else begin
         rd_state    <= next_rd_state;
         o_mem_rd_en <= (rd_state == mbt_pkg::MBT_RD_REQ);
      end
   end

   // Mode and direction held for the whole transfer
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fill_q <= 1'h0;
         down_q <= 1'h0;
      end else if (start) begin
         fill_q <= i_fill_mode;
         down_q <= go_down;
      end
   end

   // Read address and bytes still to fetch
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_mem_rd_addr <= '0;
         rd_left       <= '0;
      end else if (start) begin
         o_mem_rd_addr <= src_init;
         rd_left       <= len;
      end else if (pushed) begin
         rd_left <= rd_left - 1'h1;
         if (!fill_q && !rd_last) begin
            o_mem_rd_addr <= rd_step;
         end
      end
   end

   // Byte returned by the memory
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         byte_q <= '0;
      end else if (rd_got) begin
         byte_q <= i_mem_rd_data;
      end
   end

   // Writer: drains the FIFO one byte per accepted write
   // byte granularity in both modes
   wire wr_last = (wr_left == LW'(1));

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_mem_wr_en   <= 1'h0;
         o_mem_wr_addr <= '0;
         o_mem_wr_data <= '0;
      end else if (popped) begin
         o_mem_wr_en   <= 1'h1;
         o_mem_wr_addr <= wr_next;
         o_mem_wr_data <= f_out_data;
      end else if (wr_taken) begin
         o_mem_wr_en <= 1'h0;
      end
   end

   // Write address and bytes still to store
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_next <= '0;
         wr_left <= '0;
      end else if (start) begin
         wr_next <= dst_init;
         wr_left <= len;
      end else begin
         if (popped) begin
            wr_next <= wr_step;
         end
         if (wr_taken) begin
            wr_left <= wr_left - 1'h1;
         end
      end
   end

   // Busy from start to the last accepted write
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_busy <= 1'h0;
         o_done <= 1'h0;
      end else begin
         o_done <= wr_taken && wr_last;
         if (start) begin
            o_busy <= 1'h1;
         end else if (wr_taken && wr_last) begin
            o_busy <= 1'h0;
         end
      end
   end
endmodule

// >>> rtl/mbt_defs.svh
// Constants of the marker block transfer engine
`ifndef MBT_DEFS_SVH
`define MBT_DEFS_SVH
`define MBT_LEN_W        11
`define MBT_MAX_COUNT    11'h400
`define MBT_KIND_BYTE    2'h0
`define MBT_KIND_WORD    2'h1
`define MBT_KIND_DWORD   2'h2
`define MBT_WORD_SHIFT   1
`define MBT_DWORD_SHIFT  2
`define MBT_INDEX_BASE   32'h1
`define MBT_FILL_SRC_LEN 32'h1
`define MBT_FIFO_DEPTH   8
`endif

// >>> rtl/mbt_pkg.sv
// Types shared by the marker block transfer engine
package mbt_pkg;
   typedef struct packed {
      logic [31:0] src_off;
      logic [31:0] dst_off;
   } mbt_span_type;
   typedef enum logic [1:0] {
      MBT_RD_IDLE,
      MBT_RD_REQ,
      MBT_RD_WAIT,
      MBT_RD_PUSH
   } mbt_rd_state_type;
endpackage

// >>> sim/mbt_mem_model.sv
// Behavioural marker byte memory on the far side
`timescale 1ns/1ps
module mbt_mem_model (
   input  wire logic       i_clk,
   input  wire logic       i_slow,
   input  wire logic       i_rd_en,
   input  wire logic [8:0] i_rd_addr,
   output logic            o_rd_valid = 1'b0,
   output logic      [7:0] o_rd_data = 8'h00,
   input  wire logic       i_wr_en,
   input  wire logic [8:0] i_wr_addr,
   input  wire logic [7:0] i_wr_data,
   output logic            o_wr_ready
);
   logic [7:0] mem [512];
   logic [8:0] addr = 9'h0;
   logic [2:0] lat = 3'h0;
   logic [2:0] tick = 3'h0;
   // Slow mode grants one write in eight cycles
   assign o_wr_ready = !i_slow || tick == 3'h7;
   always @(posedge i_clk) begin
      tick <= tick + 3'h1;
      o_rd_valid <= 1'b0;
      // Idle data lines toggle
      o_rd_data <= ~o_rd_data;
      if (i_rd_en) begin
         addr <= i_rd_addr;
         lat <= i_slow ? 3'h4 : 3'h1;
      end else if (lat == 3'h1) begin
         lat <= 3'h0;
         o_rd_valid <= 1'b1;
         o_rd_data <= mem[addr];
      end else if (lat != 3'h0) begin
         lat <= lat - 3'h1;
      end
      if (i_wr_en && o_wr_ready) begin
         mem[i_wr_addr] <= i_wr_data;
      end
   end
endmodule

// >>> sim/mbt_properties.sv
// Port checker of the block transfer engine
`timescale 1ns/1ps
module mbt_properties #(
   parameter int CW  = 16,
   parameter int MAW = 9
) (
   input wire logic           i_core_clk,
   input wire logic           i_resetn,
   input wire logic           i_trigger,
   input wire logic           i_enable,
   input wire logic           i_enable_release,
   input wire logic [CW-1:0]  i_count,
   input wire logic           i_mem_wr_ready,
   input wire logic           o_mem_rd_en,
   input wire logic           o_mem_wr_en,
   input wire logic [MAW-1:0] o_mem_wr_addr,
   input wire logic [7:0]     o_mem_wr_data,
   input wire logic           o_busy,
   input wire logic           o_done,
   input wire logic           o_count_overrun_err,
   input wire logic           o_legacy_error_out,
   input wire logic           o_address_range_err
);
   logic [1:0] up;
   // Waits out the internal reset release
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         up <= 2'h0;
      end else if (up != 2'h3) begin
         up <= up + 2'h1;
      end
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (up != 2'h3);
   legacy_low_a: assert property (!o_legacy_error_out)
      else $error("legacy output set");
   zero_count_a: assert property (i_count == '0 |=> o_address_range_err)
      else $error("zero count passed");
   big_count_a: assert property (i_count > 1024 |=> o_count_overrun_err || o_address_range_err)
      else $error("overrun missed");
   start_cause_a: assert property ($rose(o_busy) |->
      $past(i_trigger) && (!$past(i_enable_release) || $past(i_enable)))
      else $error("start without cause");
   start_clean_a: assert property ($rose(o_busy) |-> !o_count_overrun_err && !o_address_range_err)
      else $error("start under error");
   read_follows_a: assert property ($rose(o_busy) |=> o_mem_rd_en)
      else $error("read late");
   read_pulse_a: assert property (o_mem_rd_en |=> !o_mem_rd_en)
      else $error("read strobe held");
   write_hold_a: assert property (o_mem_wr_en && !i_mem_wr_ready |=>
      o_mem_wr_en && $stable(o_mem_wr_addr) && $stable(o_mem_wr_data))
      else $error("write dropped");
   done_end_a: assert property ($fell(o_busy) |-> o_done)
      else $error("done missing");
   idle_quiet_a: assert property (!o_busy |-> !o_mem_rd_en && !o_mem_wr_en)
      else $error("access while idle");
   cover property ($rose(o_busy));
   cover property (o_mem_wr_en && !i_mem_wr_ready);
   cover property (o_count_overrun_err);
endmodule
bind mbt_block_transfer mbt_properties #(.CW(CW), .MAW(MAW)) i_mbt_properties (
   .i_core_clk, .i_resetn, .i_trigger, .i_enable, .i_enable_release, .i_count,
   .i_mem_wr_ready, .o_mem_rd_en, .o_mem_wr_en, .o_mem_wr_addr, .o_mem_wr_data, .o_busy,
   .o_done, .o_count_overrun_err, .o_legacy_error_out, .o_address_range_err);

// >>> sim/tb.sv
// Self-checking bench of the block transfer engine
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
   $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb;
   logic        i_core_clk = 1'b0, i_resetn = 1'b0, i_enable = 1'b1, i_enable_release = 1'b1;
   logic        i_trigger = 1'b0, i_fill_mode = 1'b0, slow = 1'b0;
   logic [15:0] i_source_offset = 16'h0, i_dest_offset = 16'h0, i_count = 16'h1;
   logic [1:0]  i_source_kind = 2'h0, i_dest_kind = 2'h0;
   logic        o_mem_rd_en, i_mem_rd_valid, o_mem_wr_en, i_mem_wr_ready, o_busy, o_done;
   logic        o_count_overrun_err, o_legacy_error_out, o_address_range_err;
   logic [8:0]  o_mem_rd_addr, o_mem_wr_addr;
   logic [7:0]  i_mem_rd_data, o_mem_wr_data, snap [512], expd [512];
   int          errors = 0, checks_done = 0;
   always #12.5 i_core_clk = ~i_core_clk;
   mbt_block_transfer i_mbt_block_transfer (
      .i_core_clk, .i_resetn, .i_enable, .i_enable_release, .i_trigger, .i_fill_mode,
      .i_source_offset, .i_source_kind, .i_dest_offset, .i_dest_kind, .i_count,
      .o_mem_rd_en, .o_mem_rd_addr, .i_mem_rd_valid, .i_mem_rd_data, .o_mem_wr_en,
      .o_mem_wr_addr, .o_mem_wr_data, .i_mem_wr_ready, .o_busy, .o_done,
      .o_count_overrun_err, .o_legacy_error_out, .o_address_range_err);
   mbt_mem_model i_mbt_mem_model (
      .i_clk(i_core_clk), .i_slow(slow), .i_rd_en(o_mem_rd_en), .i_rd_addr(o_mem_rd_addr),
      .o_rd_valid(i_mem_rd_valid), .o_rd_data(i_mem_rd_data), .i_wr_en(o_mem_wr_en),
      .i_wr_addr(o_mem_wr_addr), .i_wr_data(o_mem_wr_data), .o_wr_ready(i_mem_wr_ready));
   function automatic int boff(input int v, input logic [1:0] k);
      return (k == 2'h0) ? v : (k == 2'h1) ? (v - 1) * 2 : (v - 1) * 4;
   endfunction
   task automatic stop_test;
      if (errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic run(input logic f, input logic [1:0] sk, input int so, input logic [1:0] dk,
                      input int dof, input int cn, input logic go);
      int s, d, k;
      logic re, oe, ok, seen;
      s = boff(so, sk);
      d = boff(dof, dk);
      re = (sk != 0 && so == 0) || (dk != 0 && dof == 0) || s >= 512 || d >= 512 || cn == 0;
      oe = !re && (cn > 1024 || s + (f ? 1 : cn) > 512 || d + cn > 512);
      ok = go && !re && !oe;
      seen = 1'b0;
      @(negedge i_core_clk);
      i_fill_mode = f;
      i_source_kind = sk;
      i_source_offset = so[15:0];
      i_dest_kind = dk;
      i_dest_offset = dof[15:0];
      i_count = cn[15:0];
      slow = 1'($urandom);
      @(negedge i_core_clk);
      `CHK(o_address_range_err, re)
      `CHK(o_count_overrun_err, oe)
      `CHK(o_legacy_error_out, 1'b0)
      for (k = 0; k < 512; k++) snap[k] = i_mbt_mem_model.mem[k];
      expd = snap;
      for (k = 0; ok && k < cn; k++) expd[d + k] = snap[f ? s : s + k];
      i_trigger = 1'b1;
      for (k = 0; k < (ok ? 20 * cn + 20 : 8) && !o_done; k++) begin
         @(negedge i_core_clk);
         seen |= o_busy;
      end
      `CHK(o_done, ok)
      `CHK(seen, ok)
      repeat (4) @(negedge i_core_clk);
      `CHK(o_busy, 1'b0)
      for (k = 0; k < 512; k++) `CHK(i_mbt_mem_model.mem[k], expd[k])
      i_trigger = 1'b0;
   endtask
   initial begin
      void'($urandom(32'hf621cd18));
      for (int k = 0; k < 512; k++) i_mbt_mem_model.mem[k] = 8'($urandom);
      repeat (5) @(negedge i_core_clk);
      i_resetn = 1'b1;
      repeat (3) @(negedge i_core_clk);
      run(0, 2'h0, 10, 2'h0, 12, 20, 1);
      run(0, 2'h0, 30, 2'h0, 25, 20, 1);
      run(1, 2'h2, 6, 2'h0, 100, 9, 1);
      run(1, 2'h1, 3, 2'h1, 60, 5, 1);
      run(0, 2'h1, 0, 2'h0, 40, 4, 1);
      run(0, 2'h0, 511, 2'h0, 0, 1, 1);
      run(0, 2'h0, 511, 2'h0, 0, 2, 1);
      run(1, 2'h0, 5, 2'h0, 0, 1025, 1);
      run(0, 2'h0, 0, 2'h0, 512, 1, 1);
      i_enable = 1'b0;
      run(0, 2'h0, 0, 2'h0, 50, 3, 0);
      i_enable_release = 1'b0;
      run(0, 2'h0, 0, 2'h0, 50, 3, 1);
      for (int n = 0; n < 60; n++) begin
         i_enable_release = 1'($urandom);
         i_enable = 1'($urandom);
         run(1'($urandom), 2'($urandom % 3), $urandom % 300, 2'($urandom % 3),
             $urandom % 300, $urandom % 48, !i_enable_release || i_enable);
      end
      stop_test();
   end
   initial begin
      #1750000;
      errors++;
      stop_test();
   end
endmodule
